// ### src/valve_loop_pkg.sv
/*
 * Package for the valve loop supervision block: APB register map,
 * field positions, reset values, mode codes and timing constants.
 * Assumes a 250 MHz system clock and a 32-bit APB slave.
 */
package valve_loop_pkg;

    // Clock and tick timing
    localparam int CLK_MHZ = 250;                        // System clock rate
    localparam int TICK_US = 1000;                       // Window tick period, microseconds
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;      // Cycles per 1 ms tick
    localparam int WIN_DELAY_MAX_MS = 100;               // Longest window delay

    // Data widths
    localparam int DW = 16;                              // Deviation and current width
    localparam int IW = 24;                              // Integral accumulator width

    // Register byte offsets (chosen)
    localparam logic [7:0] OFF_CTRL = 8'h00;             // Modes and option bits
    localparam logic [7:0] OFF_IWIN = 8'h04;             // Outer and inner windows
    localparam logic [7:0] OFF_ITIME = 8'h08;            // Integration and reduction shifts
    localparam logic [7:0] OFF_WTHR = 8'h0C;             // Target and trailing thresholds
    localparam logic [7:0] OFF_WOFF = 8'h10;             // Solenoid-off threshold
    localparam logic [7:0] OFF_WDLY = 8'h14;             // Three window delays
    localparam logic [7:0] OFF_CUR = 8'h18;              // Min and max current
    localparam logic [7:0] OFF_DEV = 8'h1C;              // Deviation input, write
    localparam logic [7:0] OFF_DEM = 8'h20;              // Current demands A and B
    localparam logic [7:0] OFF_STAT = 8'h24;             // Status, read only
    localparam logic [7:0] OFF_ITERM = 8'h28;            // Integral term, read only
    localparam logic [7:0] OFF_OUT = 8'h2C;              // Output currents, read only

    // CTRL field positions
    localparam int F_CMODE = 0;                          // Controller mode, 4 bits
    localparam int F_OPMODE = 4;                         // Operating mode, 2 bits
    localparam int F_INV_A = 6;
    localparam int F_INV_B = 7;
    localparam int F_IMIN_ON = 8;
    localparam int F_SWAP = 9;
    localparam int F_INPOS = 10;
    localparam int F_IPOL = 11;                          // Out-of-window policy, 2 bits
    localparam int F_ERRPAT = 13;                        // Error pattern, 2 bits
    localparam int F_ENABLE = 15;                        // Controller enabled
    localparam int F_ERROR = 16;                         // Error state
    localparam int F_SIGTYPE = 17;                       // Signal type, 2 bits
    localparam logic [31:0] CTRL_RESET = 32'h0000_0009;  // Mode 9, all options off

    // Controller modes
    localparam logic [3:0] CM_OL_PQ = 4'h3;
    localparam logic [3:0] CM_CL_PQ = 4'h4;
    localparam logic [3:0] CM_OL_POS = 4'h6;
    localparam logic [3:0] CM_CL_SPD = 4'h7;
    localparam logic [3:0] CM_CL_POS = 4'h9;

    // Operating modes
    typedef enum logic [1:0] {
        OP_UNI_1SOL, OP_UNI_2SOL, OP_BIP_2SOL, OP_UNI_2SOL_IND
    } opmode_t;

    // Signal types
    localparam logic [1:0] SIG_V10 = 2'h0;               // 0..10 V
    localparam logic [1:0] SIG_BIP10 = 2'h1;             // +/-10 V

    // Out-of-window integral policy
    typedef enum logic [1:0] {
        IP_CLEAR, IP_HOLD, IP_REDUCE, IP_RSVD
    } ipolicy_t;

    // Error patterns
    localparam logic [1:0] EP_OFF = 2'h0;
    localparam logic [1:0] EP_A = 2'h1;
    localparam logic [1:0] EP_B = 2'h2;
    localparam logic [1:0] EP_AB = 2'h3;

endpackage : valve_loop_pkg

// ### src/valve_loop_window_and_mode_logic.sv
/*
 * Loop supervision: integral band selection, target, trailing-error and
 * solenoid-off windows with debounce counted in 1 ms ticks, mode decode and solenoid
 * output options. Assumes an APB master on mclk and software that
 * writes the deviation and current demands.
 */
//
// Function
// - Positive band integrates with positive time
// - Negative band integrates with negative time
// - Inner bands hold the integral term
// - Beyond outer window apply integral policy
// - Target flag after debounced crossing delay
// - Trailing error after debounced excess delay
// - Solenoid-off window, debounced, outputs off
// - In-position option keeps solenoids driven
// - Controller modes 3, 4, 6, 7, 9
// - Per-output inversion refused in 6, 9
// - Minimum current clamp when option set
// - Swap routes demand A to B
// - Operating mode only in modes 3, 6
// - Mode/scaling changes only while disabled
// - Four operating mode values
// - Operating mode adjusts signal type
// - Error pattern: 0 or two-thirds range
// - Integrate only inside outer window
// - Reduce decays; zero time freezes
`timescale 1ns/10ps
`default_nettype none

module valve_loop_window_and_mode_logic
    import valve_loop_pkg::*;
#(
    parameter int TICK_DIV = valve_loop_pkg::TICK_CYCLES  // Cycles per window tick
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [valve_loop_pkg::DW-1:0] sol_a_current,
    output logic [valve_loop_pkg::DW-1:0] sol_b_current,
    output logic target_reached,
    output logic trailing_error,
    output logic sol_off_active
);
    import valve_loop_pkg::*;

    // Configuration registers
    logic [31:0] ctrl;
    logic [31:0] iwin, itime, wthr, woff, wdly, cur, dem;
    logic signed [DW-1:0] dev;                      // Control deviation
    logic signed [IW-1:0] iterm;                    // Integral accumulator
    logic [19:0] tick_cnt;                          // Tick divider
    logic tick;

    // Field decode
    wire [3:0] cmode = ctrl[F_CMODE +: 4];
    wire enabled = ctrl[F_ENABLE];
    wire in_err = ctrl[F_ERROR];
    wire [1:0] errpat = ctrl[F_ERRPAT +: 2];
    wire ipolicy_t ipol = ipolicy_t'(ctrl[F_IPOL +: 2]);
    wire [DW-1:0] max_solenoid_current = cur[31:16];
    wire [DW-1:0] min_current = cur[15:0];

    // APB decode
    wire wr_en = psel & penable & pwrite & pready;
    wire known = (paddr <= OFF_OUT) && (paddr[1:0] == 2'b00);
    wire cmode_ok = (pwdata[F_CMODE +: 4] == CM_OL_PQ) || (pwdata[F_CMODE +: 4] == CM_CL_PQ)
                 || (pwdata[F_CMODE +: 4] == CM_OL_POS) || (pwdata[F_CMODE +: 4] == CM_CL_SPD)
                 || (pwdata[F_CMODE +: 4] == CM_CL_POS);
    // Mode after this write; a refused code must not let inversion slip through
    wire [3:0] new_cmode = (enabled || !cmode_ok) ? cmode : pwdata[F_CMODE +: 4];
    wire inv_refused = (new_cmode == CM_OL_POS) || (new_cmode == CM_CL_POS);
    wire op_allowed = (new_cmode == CM_OL_PQ) || (new_cmode == CM_OL_POS);
    wire [1:0] req_op = pwdata[F_OPMODE +: 2];
    // Bipolar operation needs the bipolar input; others fall back to 0..10 V
    wire [1:0] auto_sig = (req_op == OP_BIP_2SOL) ? SIG_BIP10 : SIG_V10;

    // Next control word; mode and scaling fields frozen while enabled
    logic [31:0] next_ctrl;
    always_comb begin
        next_ctrl = pwdata;
        next_ctrl[F_CMODE +: 4] = new_cmode;
        if (enabled) begin
            next_ctrl[F_OPMODE +: 2] = ctrl[F_OPMODE +: 2];
            next_ctrl[F_SIGTYPE +: 2] = ctrl[F_SIGTYPE +: 2];
        end else if (op_allowed) begin
            next_ctrl[F_OPMODE +: 2] = req_op;
            next_ctrl[F_SIGTYPE +: 2] = auto_sig;
        end else begin
            next_ctrl[F_OPMODE +: 2] = OP_UNI_1SOL;
            next_ctrl[F_SIGTYPE +: 2] = SIG_V10;
        end
        if (inv_refused) begin
            next_ctrl[F_INV_A] = 1'b0;
            next_ctrl[F_INV_B] = 1'b0;
        end
        next_ctrl[31:19] = 13'h0000;
    end

    // Register writes; zero-wait slave
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
            iwin <= 32'h0000_0000;
            itime <= 32'h0000_0000;
            wthr <= 32'h0000_0000;
            woff <= 32'h0000_0000;
            wdly <= 32'h0000_0000;
            cur <= 32'h0000_0000;
            dem <= 32'h0000_0000;
            dev <= '0;
        end else if (wr_en) begin
            case (paddr)
                OFF_CTRL: ctrl <= next_ctrl;
                OFF_IWIN: iwin <= pwdata;
                OFF_ITIME: itime <= pwdata;
                OFF_WTHR: wthr <= pwdata;
                OFF_WOFF: woff <= pwdata;
                OFF_WDLY: wdly <= pwdata;
                OFF_CUR: cur <= pwdata;
                OFF_DEV: dev <= pwdata[DW-1:0];
                OFF_DEM: dem <= pwdata;
                default: ;
            endcase
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            OFF_CTRL: rd_mux = ctrl;
            OFF_IWIN: rd_mux = iwin;
            OFF_ITIME: rd_mux = itime;
            OFF_WTHR: rd_mux = wthr;
            OFF_WOFF: rd_mux = woff;
            OFF_WDLY: rd_mux = wdly;
            OFF_CUR: rd_mux = cur;
            OFF_DEV: rd_mux = {{(32-DW){dev[DW-1]}}, dev};
            OFF_DEM: rd_mux = dem;
            OFF_STAT: rd_mux = {29'h0000_0000, sol_off_active, trailing_error, target_reached};
            OFF_ITERM: rd_mux = {{(32-IW){iterm[IW-1]}}, iterm};
            OFF_OUT: rd_mux = {sol_b_current, sol_a_current};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer: ready in the access cycle, read data registered in setup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata <= (psel & ~penable) ? rd_mux : prdata;
        end
    end

    // 1 ms tick divider
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 20'(TICK_DIV - 1));
            tick_cnt <= (tick_cnt == 20'(TICK_DIV - 1)) ? '0 : tick_cnt + 20'd1;
        end
    end

    // Deviation magnitude and integral bands
    wire signed [DW-1:0] abs_dev = dev[DW-1] ? -dev : dev;
    wire [7:0] out_pos = iwin[7:0], in_pos = iwin[15:8];
    wire [7:0] out_neg = iwin[23:16], in_neg = iwin[31:24];
    wire pos_side = ~dev[DW-1];
    wire in_inner = pos_side ? (abs_dev <= $signed({8'h00, in_pos}))
                             : (abs_dev <= $signed({8'h00, in_neg}));
    wire in_outer = pos_side ? (abs_dev < $signed({8'h00, out_pos}))
                             : (abs_dev < $signed({8'h00, out_neg}));
    wire [4:0] sh_pos = itime[4:0], sh_neg = itime[12:8], sh_red = itime[20:16];
    wire [4:0] sh_int = pos_side ? sh_pos : sh_neg;
    wire signed [IW-1:0] dev_ext = IW'(dev);
    wire signed [IW-1:0] step = dev_ext >>> sh_int;
    wire signed [IW-1:0] decay = iterm >>> sh_red;

    // Integral term; shift of 0 means time 0, no integration
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            iterm <= '0;
        end else if (sh_pos == 5'd0 && sh_neg == 5'd0) begin
            iterm <= '0;
        end else if (tick) begin
            if (in_inner) begin
                iterm <= iterm;
            end else if (in_outer) begin
                if (sh_int != 5'd0) begin
                    iterm <= iterm + step;
                end
            end else begin
                case (ipol)
                    IP_CLEAR: iterm <= '0;
                    IP_REDUCE: iterm <= (sh_red == 5'd0) ? iterm : iterm - decay;
                    default: iterm <= iterm;
                endcase
            end
        end
    end

    // Raw window conditions
    wire raw_target = abs_dev <= $signed({8'h00, wthr[7:0]});
    wire raw_trail = abs_dev > $signed({8'h00, wthr[23:16]});
    wire raw_off = abs_dev <= $signed(woff[DW-1:0]);
    logic next_off;
    // Debounced windows, one instance each
    win_debounce u_target (
        .mclk(mclk), .rst(rst), .tick(tick), .raw(raw_target),
        .delay(wdly[7:0]), .both_edges(1'b1), .flag(target_reached));
    win_debounce u_trail (
        .mclk(mclk), .rst(rst), .tick(tick), .raw(raw_trail),
        .delay(wdly[15:8]), .both_edges(1'b0), .flag(trailing_error));
    win_debounce u_off (
        .mclk(mclk), .rst(rst), .tick(tick), .raw(raw_off),
        .delay(wdly[23:16]), .both_edges(1'b1), .flag(next_off));

    // Output current path
    wire [DW-1:0] dem_a = ctrl[F_SWAP] ? dem[31:16] : dem[15:0];
    wire [DW-1:0] dem_b = ctrl[F_SWAP] ? dem[15:0] : dem[31:16];
    wire [DW-1:0] inv_a = ctrl[F_INV_A] ? max_solenoid_current - dem_a : dem_a;
    wire [DW-1:0] inv_b = ctrl[F_INV_B] ? max_solenoid_current - dem_b : dem_b;
    wire [DW-1:0] clmp_a = (ctrl[F_IMIN_ON] && inv_a < min_current) ? min_current : inv_a;
    wire [DW-1:0] clmp_b = (ctrl[F_IMIN_ON] && inv_b < min_current) ? min_current : inv_b;
    wire [DW+1:0] span2 = {1'b0, max_solenoid_current - min_current, 1'b0};
    wire [DW-1:0] err_on = min_current + DW'(span2 / 3);
    wire off_gate = next_off & ~ctrl[F_INPOS];

    // Output registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sol_a_current <= '0;
            sol_b_current <= '0;
            sol_off_active <= 1'b0;
        end else begin
            sol_off_active <= off_gate;
            if (in_err) begin
                sol_a_current <= (errpat == EP_A || errpat == EP_AB) ? err_on : '0;
                sol_b_current <= (errpat == EP_B || errpat == EP_AB) ? err_on : '0;
            end else if (!enabled || off_gate) begin
                sol_a_current <= '0;
                sol_b_current <= '0;
            end else begin
                sol_a_current <= clmp_a;
                sol_b_current <= clmp_b;
            end
        end
    end

    // Checks
    property p_off_zero;
        @(posedge mclk) disable iff (rst)
        (off_gate && !in_err) |=> (sol_a_current == '0 && sol_b_current == '0);
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("solenoid-off not zero");
    property p_inpos;
        @(posedge mclk) disable iff (rst) ctrl[F_INPOS] |=> !sol_off_active;
    endproperty
    a_inpos: assert property (p_inpos) else $error("in-position ignored");
    property p_inv;
        @(posedge mclk) disable iff (rst)
        (cmode == CM_OL_POS || cmode == CM_CL_POS) |-> !(ctrl[F_INV_A] || ctrl[F_INV_B]);
    endproperty
    a_inv: assert property (p_inv) else $error("inversion in mode 6 or 9");
    property p_imin;
        @(posedge mclk) disable iff (rst)
        (ctrl[F_IMIN_ON] && enabled && !in_err && !off_gate) |=> sol_a_current >= $past(min_current);
    endproperty
    a_imin: assert property (p_imin) else $error("current below minimum");
    property p_frozen;
        @(posedge mclk) disable iff (rst)
        enabled && $past(enabled) |-> $stable(cmode);
    endproperty
    a_frozen: assert property (p_frozen) else $error("mode changed while enabled");
    property p_err;
        @(posedge mclk) disable iff (rst) (in_err && errpat == EP_OFF) |=> sol_b_current == '0;
    endproperty
    a_err: assert property (p_err) else $error("error pattern off not zero");
    property p_inner;
        @(posedge mclk) disable iff (rst)
        (tick && in_inner && (sh_pos != 5'd0 || sh_neg != 5'd0)) |=> $stable(iterm);
    endproperty
    a_inner: assert property (p_inner) else $error("integral moved in inner band");
    property p_clear;
        @(posedge mclk) disable iff (rst)
        (tick && !in_outer && !in_inner && ipol == IP_CLEAR) |=> iterm == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("integral not cleared");

endmodule : valve_loop_window_and_mode_logic

// Debounce: flag follows raw after delay ticks of steady raw
module win_debounce (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic raw,
    input wire logic [7:0] delay,
    input wire logic both_edges,
    output logic flag
);
    logic [7:0] cnt;
    // Restart on any change; falling edge immediate unless both_edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            flag <= 1'b0;
        end else if (raw == flag) begin
            cnt <= 8'h00;
        end else if (!raw && !both_edges) begin
            flag <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt >= delay) begin
            flag <= raw;
            cnt <= 8'h00;
        end else if (tick) begin
            cnt <= cnt + 8'h01;
        end
    end

endmodule : win_debounce
`default_nettype wire

// ### bench/sol_driver_model.sv
/*
 * Behavioural model of the two solenoid driver stages at the far side.
 * Assumes the current words arrive registered on mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module sol_driver_model
    import valve_loop_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [valve_loop_pkg::DW-1:0] sol_a_current,
    input wire logic [valve_loop_pkg::DW-1:0] sol_b_current,
    output logic a_energised,
    output logic b_energised
);
    // Coil state, one cycle behind the command like a real stage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_energised <= 1'b0;  // Coils start released
            b_energised <= 1'b0;
        end else begin
            a_energised <= sol_a_current != '0;  // Any nonzero word pulls in
            b_energised <= sol_b_current != '0;
        end
    end
endmodule : sol_driver_model

`default_nettype wire

// ### bench/valve_loop_window_and_mode_logic_tb.sv
/*
 * Self-checking bench: APB tasks, then mode, output, window, integral and
 * reset tests. Assumes the design package and a 4-cycle window tick.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
end

module valve_loop_window_and_mode_logic_tb;
    import valve_loop_pkg::*;

    localparam int TDIV = 4;  // Short tick keeps ms delays to a few cycles
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [DW-1:0] sol_a_current;
    logic [DW-1:0] sol_b_current;
    logic target_reached;
    logic trailing_error;
    logic sol_off_active;
    logic a_energised;
    logic b_energised;
    int miscompares = 0;
    int comparisons = 0;
    int cnt;  // Cycles spent in the last flag wait
    logic [31:0] rd;  // Last read word
    logic err;  // Last slave error
    logic signed [23:0] it0;
    logic signed [23:0] it1;
    logic [3:0] cm [5] = '{CM_OL_PQ, CM_CL_PQ, CM_OL_POS, CM_CL_SPD, CM_CL_POS};

    valve_loop_window_and_mode_logic #(.TICK_DIV(TDIV)) valve_loop_window_and_mode_logic_i (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sol_a_current(sol_a_current), .sol_b_current(sol_b_current),
        .target_reached(target_reached), .trailing_error(trailing_error),
        .sol_off_active(sol_off_active));

    sol_driver_model sol_driver_model_i (
        .mclk(mclk), .rst(rst), .sol_a_current(sol_a_current),
        .sol_b_current(sol_b_current), .a_energised(a_energised), .b_energised(b_energised));

    // 250 MHz clock
    initial begin
        forever #2 mclk = ~mclk;
    end

    // Verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // Let n edges pass, then step off the edge
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    // One APB transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // Read and compare the masked field
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd & m)
    endtask : rdchk

    task automatic get_it(output logic signed [23:0] v);
        apb(1'b0, OFF_ITERM, 32'h0000_0000);
        v = rd[23:0];
    endtask : get_it

    // Both output currents after they settle
    task automatic chk_out(input string nm, input logic [15:0] ea, input logic [15:0] eb);
        idle(2);
        `CHK(nm, ea, sol_a_current)
        `CHK(nm, eb, sol_b_current)
    endtask : chk_out

    // Bounded wait for a flag (0 target, 1 trailing, 2 solenoid-off)
    task automatic waitf(input int idx, input logic v, input int lim);
        logic [2:0] f;
        cnt = 0;
        f = {sol_off_active, trailing_error, target_reached};
        while (f[idx] !== v) begin
            idle(1);
            cnt++;
            f = {sol_off_active, trailing_error, target_reached};
            if (cnt > lim) begin
                miscompares++;
                $display("[FAIL] flag %0d expected %b seen %b", idx, v, f[idx]);
                end_sim();
            end
        end
    endtask : waitf

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        #1;
        `CHK("a_rst", 16'h0000, sol_a_current);
        rdchk("ctrl_rst", OFF_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
        apb(1'b0, 8'h30, 32'h0000_0000);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd});
        foreach (cm[i]) begin
            wr(OFF_CTRL, {28'h000_0000, cm[i]});
            rdchk("cmode", OFF_CTRL, 32'h0000_000F, {28'h000_0000, cm[i]});
        end
        wr(OFF_CTRL, 32'h0000_0005);
        rdchk("cmode_bad", OFF_CTRL, 32'h0000_000F, 32'h0000_0009);
        wr(OFF_CTRL, 32'h0000_00C9);
        rdchk("inv_m9", OFF_CTRL, 32'h0000_00C0, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_00C3);
        rdchk("inv_m3", OFF_CTRL, 32'h0000_00C0, 32'h0000_00C0);
        wr(OFF_CTRL, 32'h0000_0024);
        rdchk("op_m4", OFF_CTRL, 32'h0000_0030, 32'h0000_0000);
        for (int op = 0; op < 4; op++) begin
            wr(OFF_CTRL, 32'h0000_0006 | (op << 4));
            rdchk("op_sig", OFF_CTRL, 32'h0006_0030,
                  (op << 4) | (op == int'(OP_BIP_2SOL) ? 32'h0002_0000 : 0));
        end
        wr(OFF_CTRL, 32'h0000_8009);
        wr(OFF_CTRL, 32'h0000_8023);
        rdchk("locked", OFF_CTRL, 32'h0000_003F, 32'h0000_0009);
        $display("test modes done");
        // Outputs, deviation kept outside every window
        wr(OFF_WOFF, 32'h0000_0008);
        wr(OFF_WTHR, 32'h0040_0010);
        wr(OFF_WDLY, 32'h0000_0000);
        wr(OFF_CUR, 32'h0800_0200);
        wr(OFF_DEM, 32'h0456_0123);
        wr(OFF_DEV, 32'h0000_0080);
        wr(OFF_CTRL, 32'h0000_8209);
        chk_out("swap", 16'h0456, 16'h0123);
        wr(OFF_CTRL, 32'h0000_8109);
        chk_out("imin", 16'h0200, 16'h0456);
        wr(OFF_CTRL, 32'h0000_0009);
        wr(OFF_CTRL, 32'h0000_0043);
        wr(OFF_CTRL, 32'h0000_8043);
        idle(2);
        `CHK("inv_a", 16'h06DD, sol_a_current);
        wr(OFF_CTRL, 32'h0000_0009);
        wr(OFF_CUR, 32'h0300_0000);
        for (int p = 0; p < 4; p++) begin
            wr(OFF_CTRL, 32'h0001_8009 | (p << 13));
            chk_out("err_pat", p[0] ? 16'h0200 : 16'h0000, p[1] ? 16'h0200 : 16'h0000);
        end
        wr(OFF_CUR, 32'h0800_0200);
        wr(OFF_CTRL, 32'h0000_8009);
        // Solenoid-off window with a 2 ms debounce
        wr(OFF_WDLY, 32'h0002_0203);
        wr(OFF_DEV, 32'h0000_0002);
        waitf(2, 1'b1, 40);
        `CHK("off_delay", 1'b1, cnt >= 3);
        chk_out("sol_off", 16'h0000, 16'h0000);
        `CHK("coil_a", 1'b0, a_energised);
        `CHK("coil_b", 1'b0, b_energised);
        wr(OFF_CTRL, 32'h0000_8409);
        chk_out("in_pos", 16'h0123, 16'h0456);
        wr(OFF_CTRL, 32'h0000_8009);
        wr(OFF_DEV, 32'h0000_0080);
        waitf(2, 1'b0, 40);
        `CHK("off_exit", 1'b1, cnt >= 3);
        $display("test outputs done");
        // Target (3 ms) and trailing (2 ms) windows
        waitf(0, 1'b0, 40);
        wr(OFF_DEV, 32'h0000_0004);
        waitf(0, 1'b1, 40);
        `CHK("tgt_in", 1'b1, cnt >= 7);
        `CHK("trail_clr", 1'b0, trailing_error);
        wr(OFF_DEV, 32'h0000_0080);
        idle(1);
        `CHK("trail_wait", 1'b0, trailing_error);
        waitf(0, 1'b0, 40);
        `CHK("tgt_out", 1'b1, cnt >= 7);
        idle(4);
        `CHK("trail_set", 1'b1, trailing_error);
        wr(OFF_DEV, 32'h0000_0004);
        idle(5);
        wr(OFF_DEV, 32'h0000_0080);
        idle(5);
        wr(OFF_DEV, 32'h0000_0004);
        waitf(0, 1'b1, 40);
        `CHK("tgt_restart", 1'b1, cnt >= 7);
        $display("test windows done");
        // Integral bands and out-of-window policies
        wr(OFF_ITIME, 32'h0000_0202);
        wr(OFF_IWIN, 32'h0840_0840);
        wr(OFF_DEV, 32'h0000_0020);
        idle(40);
        get_it(it0);
        `CHK("int_pos", 1'b1, it0 > 0);
        wr(OFF_DEV, 32'h0000_0004);
        get_it(it0);
        idle(20);
        get_it(it1);
        `CHK("int_inner", it0, it1);
        wr(OFF_CTRL, 32'h0000_8809);
        wr(OFF_DEV, 32'h0000_0080);
        get_it(it0);
        idle(20);
        get_it(it1);
        `CHK("int_hold", it0, it1);
        wr(OFF_CTRL, 32'h0000_9009);
        idle(20);
        get_it(it1);
        `CHK("int_frz", it0, it1);
        wr(OFF_CTRL, 32'h0000_8009);
        idle(8);
        get_it(it1);
        `CHK("int_clr", 24'h00_0000, it1);
        wr(OFF_DEV, 32'h0000_FFE0);
        idle(40);
        get_it(it0);
        `CHK("int_neg", 1'b1, it0 < 0);
        wr(OFF_ITIME, 32'h0002_0202);
        wr(OFF_CTRL, 32'h0000_9009);
        wr(OFF_DEV, 32'h0000_FF80);
        idle(20);
        get_it(it1);
        `CHK("int_decay", 1'b1, it1 > it0);
        $display("test integral done");
        // Reset in mid-run
        @(posedge mclk);
        rst <= 1'b1;
        idle(2);
        `CHK("rst_out", 35'h0_0000_0000, {sol_a_current, sol_b_current, target_reached,
             trailing_error, sol_off_active});
        @(posedge mclk);
        rst <= 1'b0;
        get_it(it1);
        `CHK("rst_iterm", 24'h00_0000, it1);
        $display("test reset done");
        end_sim();
    end
endmodule : valve_loop_window_and_mode_logic_tb

`default_nettype wire
